//--- ptfc_pkg.sv
// Constants shared by the translation fault classifier: register map,
// fault reason codes, completion status encodings and field widths.
// Assumes a single 10 MHz clock domain and a plain strobe register port.
package ptfc_pkg;

  // ************************************************************
  // Register map (byte offsets on the plain register port)
  // ************************************************************
  localparam int          REG_ADDR_W         = 8;
  localparam int          REG_DATA_W         = 32;
  localparam logic [7:0]  ROOT_PTR_OFFSET    = 8'h00;
  localparam logic [7:0]  LAST_FAULT_OFFSET  = 8'h04;
  localparam logic [7:0]  FAULT_COUNT_OFFSET = 8'h08;
  localparam int          ROOT_FORMAT_BIT    = 0;
  localparam logic        ROOT_FORMAT_RESET  = 1'b0;
  localparam int          LAST_REASON_LSB    = 0;
  localparam int          LAST_QUAL_BIT      = 8;
  localparam int          LAST_STATUS_LSB    = 9;
  localparam int          LAST_VALID_BIT     = 11;
  localparam int          FAULT_COUNT_W      = 16;

  // ************************************************************
  // Request header and entry fields
  // ************************************************************
  localparam logic [1:0]  KIND_TRANSLATION   = 2'h1;
  localparam int          TT_W               = 3;
  localparam int          WIDTH_CODE_W       = 3;
  localparam int          TABLE_SIZE_W       = 3;
  localparam logic [4:0]  TABLE_SIZE_SHIFT   = 5'h05;
  localparam logic [2:0]  TT_UNTRANSLATED    = 3'h1;
  localparam logic [2:0]  TT_PASID_ONLY      = 3'h5;
  localparam logic [2:0]  TT_PASID_NESTED    = 3'h7;

  // ************************************************************
  // Fault reason codes
  // ************************************************************
  localparam logic [7:0]  FR_NONE            = 8'h00;
  localparam logic [7:0]  FR_ROOT_ABSENT     = 8'h01;
  localparam logic [7:0]  FR_CTX_ABSENT      = 8'h02;
  localparam logic [7:0]  FR_CTX_BAD_PROG    = 8'h03;
  localparam logic [7:0]  FR_SS_NEXT_ERR     = 8'h07;
  localparam logic [7:0]  FR_ROOT_FETCH_ERR  = 8'h08;
  localparam logic [7:0]  FR_CTX_FETCH_ERR   = 8'h09;
  localparam logic [7:0]  FR_CTX_RSVD        = 8'h0B;
  localparam logic [7:0]  FR_TT_BLOCKED      = 8'h0D;
  localparam logic [7:0]  FR_PID_DISABLED    = 8'h10;
  localparam logic [7:0]  FR_PID_TOO_LARGE   = 8'h11;
  localparam logic [7:0]  FR_EXEC_DENIED     = 8'h19;
  localparam logic [7:0]  FR_SUPV_DENIED     = 8'h1A;
  localparam logic [7:0]  FR_ROOT_FORMAT     = 8'h1B;

  // ************************************************************
  // Completion status returned to the endpoint
  // ************************************************************
  typedef enum logic [1:0] {
    PTFC_CPL_SUCCESS = 2'b00,
    PTFC_CPL_UR      = 2'b01,
    PTFC_CPL_CA      = 2'b10
  } ptfc_cpl_t;

endpackage

//--- ptfc_top.sv
// Fault classifier for translation requests that carry a process address
// space ID. Takes one request per strobe, together with the table walk
// outcome, and answers one cycle later with reason, qualifier and status.
// Assumes the walk results are driven from logic on the same clock.
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps

module ptfc_top
  import ptfc_pkg::*;
#(
  parameter int         PASID_W            = 20,
  parameter logic [7:0] WIDTH_SUPPORT_MASK = 8'h04,
  parameter logic [7:0] TT_SUPPORT_MASK    = 8'hA2
) (
  input  wire logic                              clk_i,
  input  wire logic                              reset_i,
  // Register port
  input  wire logic [ptfc_pkg::REG_ADDR_W-1:0]   reg_addr_i,
  input  wire logic [ptfc_pkg::REG_DATA_W-1:0]   reg_wdata_i,
  input  wire logic                              reg_write_i,
  input  wire logic                              reg_read_i,
  output logic      [ptfc_pkg::REG_DATA_W-1:0]   reg_rdata_o,
  // Request
  input  wire logic                              req_valid_i,
  input  wire logic [1:0]                        request_address_kind_i,
  input  wire logic                              req_has_pasid_i,
  input  wire logic [PASID_W-1:0]                req_pasid_i,
  input  wire logic                              exec_request_flag_i,
  input  wire logic                              supervisor_request_flag_i,
  // Walk outcome
  input  wire logic                              root_fetch_err_i,
  input  wire logic                              upper_lower_present_i,
  input  wire logic                              ctx_fetch_err_i,
  input  wire logic                              ctx_present_i,
  input  wire logic                              ctx_reserved_nz_i,
  input  wire logic [ptfc_pkg::WIDTH_CODE_W-1:0] address_width_i,
  input  wire logic [ptfc_pkg::TT_W-1:0]         ctx_translation_type_i,
  input  wire logic                              process_id_enable_i,
  input  wire logic [ptfc_pkg::TABLE_SIZE_W-1:0] process_id_table_size_i,
  input  wire logic                              exec_request_allow_i,
  input  wire logic                              supervisor_request_allow_i,
  input  wire logic                              nested_enable_i,
  input  wire logic                              second_stage_root_err_i,
  input  wire logic                              process_id_entry_err_i,
  input  wire logic                              second_stage_next_err_i,
  // Answer
  output logic                                   resp_valid_o,
  output logic                                   resp_classified_o,
  output logic                                   fault_o,
  output logic      [7:0]                        fault_reason_o,
  output logic                                   fault_qualified_o,
  output ptfc_pkg::ptfc_cpl_t                    cpl_status_o
);

  import ptfc_pkg::*;

  // ************************************************************
  // Parameter checks
  // ************************************************************
  // Table size field reaches 2^12 entries; wider IDs than 20 bits are not served
  if (PASID_W < 1 || PASID_W > 20) begin : g_bad_pasid_w
    $error("PASID_W must lie between 1 and 20");
  end

  // ************************************************************
  // Register file
  // ************************************************************
  logic                      root_format_reg;
  logic                      root_format_next;
  logic [REG_DATA_W-1:0]     rdata_reg;
  logic [REG_DATA_W-1:0]     rdata_next;
  logic [FAULT_COUNT_W-1:0]  fault_count_reg;
  logic [FAULT_COUNT_W-1:0]  fault_count_next;
  logic                      last_valid_reg;
  logic                      last_valid_next;

  // ************************************************************
  // Answer registers
  // ************************************************************
  logic                      resp_valid_reg;
  logic                      resp_valid_next;
  logic                      classified_reg;
  logic                      classified_next;
  logic                      fault_reg;
  logic                      fault_next;
  logic [7:0]                reason_reg;
  logic [7:0]                reason_next;
  logic                      qual_reg;
  logic                      qual_next;
  ptfc_cpl_t                 cpl_reg;
  ptfc_cpl_t                 cpl_next;

  // ************************************************************
  // Classification
  // ************************************************************
  logic                      is_pasid_req;
  logic                      tt_allowed;
  logic                      tt_supported;
  logic                      width_supported;
  logic [4:0]                pid_shift;
  logic                      pid_too_large;
  logic                      hit;
  logic [7:0]                hit_reason;
  logic                      hit_qual;
  ptfc_cpl_t                 hit_cpl;

  // Decode of the entry fields used by the priority chain
  always_comb begin
    is_pasid_req  = (request_address_kind_i == KIND_TRANSLATION) && req_has_pasid_i;
    tt_allowed    = (ctx_translation_type_i == TT_UNTRANSLATED)
                 || (ctx_translation_type_i == TT_PASID_ONLY)
                 || (ctx_translation_type_i == TT_PASID_NESTED);
    tt_supported  = TT_SUPPORT_MASK[ctx_translation_type_i];
    width_supported = WIDTH_SUPPORT_MASK[address_width_i];
    pid_shift     = 5'(process_id_table_size_i) + TABLE_SIZE_SHIFT;
    // Table of 2^(size+5) entries; IDs above its top index fault
    pid_too_large = (32'(pid_shift) < PASID_W)
                 && ((32'(req_pasid_i) >> pid_shift) != 32'h0);
  end

  // First fault in walk order wins; later checks are never reached
  always_comb begin
    hit        = 1'b1;
    hit_reason = FR_NONE;
    hit_qual   = 1'b0;
    hit_cpl    = PTFC_CPL_UR;
    if (!root_format_reg) begin
      hit_reason = FR_ROOT_FORMAT;
    end else if (root_fetch_err_i) begin
      hit_reason = FR_ROOT_FETCH_ERR;
      hit_cpl    = PTFC_CPL_CA;
    end else if (!upper_lower_present_i) begin
      hit_reason = FR_ROOT_ABSENT;
    end else if (ctx_fetch_err_i) begin
      hit_reason = FR_CTX_FETCH_ERR;
      hit_cpl    = PTFC_CPL_CA;
    end else if (!ctx_present_i) begin
      hit_reason = FR_CTX_ABSENT;
      hit_qual   = 1'b1;
    end else if (ctx_reserved_nz_i) begin
      hit_reason = FR_CTX_RSVD;
      hit_qual   = 1'b1;
    end else if (!width_supported) begin
      hit_reason = FR_CTX_BAD_PROG;
      hit_qual   = 1'b1;
      hit_cpl    = PTFC_CPL_CA;
    end else if (!tt_allowed) begin
      hit_reason = FR_TT_BLOCKED;
      hit_qual   = 1'b1;
    end else if (!tt_supported) begin
      hit_reason = FR_CTX_BAD_PROG;
      hit_qual   = 1'b1;
      hit_cpl    = PTFC_CPL_CA;
    end else if (!process_id_enable_i) begin
      hit_reason = FR_PID_DISABLED;
      hit_qual   = 1'b1;
    end else if (pid_too_large) begin
      hit_reason = FR_PID_TOO_LARGE;
      hit_qual   = 1'b1;
    end else if (exec_request_flag_i && !exec_request_allow_i) begin
      hit_reason = FR_EXEC_DENIED;
      hit_qual   = 1'b1;
    end else if (supervisor_request_flag_i && !supervisor_request_allow_i) begin
      hit_reason = FR_SUPV_DENIED;
      hit_qual   = 1'b1;
    end else if (process_id_entry_err_i) begin
      hit_reason = FR_CTX_BAD_PROG;
      hit_qual   = 1'b1;
      hit_cpl    = PTFC_CPL_CA;
    end else if (nested_enable_i && second_stage_root_err_i) begin
      hit_reason = FR_CTX_BAD_PROG;
      hit_qual   = 1'b1;
      hit_cpl    = PTFC_CPL_CA;
    end else if (second_stage_next_err_i) begin
      hit_reason = FR_SS_NEXT_ERR;
      hit_qual   = 1'b1;
      hit_cpl    = PTFC_CPL_CA;
    end else begin
      hit        = 1'b0;
      hit_cpl    = PTFC_CPL_SUCCESS;
    end
  end

  // ************************************************************
  // Answer next state
  // ************************************************************
  // Answer fields only move on a request, so they hold for recording logic
  always_comb begin
    resp_valid_next = req_valid_i;
    classified_next = classified_reg;
    fault_next      = fault_reg;
    reason_next     = reason_reg;
    qual_next       = qual_reg;
    cpl_next        = cpl_reg;
    if (req_valid_i) begin
      classified_next = is_pasid_req;
      fault_next      = is_pasid_req && hit;
      reason_next     = is_pasid_req ? hit_reason : FR_NONE;
      qual_next       = is_pasid_req && hit_qual;
      // Other request kinds pass untouched; another checker owns them
      cpl_next        = is_pasid_req ? hit_cpl : PTFC_CPL_SUCCESS;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      resp_valid_reg <= 1'b0;
      classified_reg <= 1'b0;
      fault_reg      <= 1'b0;
      reason_reg     <= FR_NONE;
      qual_reg       <= 1'b0;
      cpl_reg        <= PTFC_CPL_SUCCESS;
    end else begin
      resp_valid_reg <= resp_valid_next;
      classified_reg <= classified_next;
      fault_reg      <= fault_next;
      reason_reg     <= reason_next;
      qual_reg       <= qual_next;
      cpl_reg        <= cpl_next;
    end
  end

  // ************************************************************
  // Register port next state
  // ************************************************************
  // Counter saturates so software never sees a wrap to zero
  always_comb begin
    root_format_next = root_format_reg;
    fault_count_next = fault_count_reg;
    last_valid_next  = last_valid_reg;
    rdata_next       = '0;
    if (reg_write_i && reg_addr_i == ROOT_PTR_OFFSET) begin
      root_format_next = reg_wdata_i[ROOT_FORMAT_BIT];
    end
    if (reg_write_i && reg_addr_i == FAULT_COUNT_OFFSET) begin
      fault_count_next = '0;
      last_valid_next  = 1'b0;
    end
    // Fault on the clear cycle still counts, so no event is lost
    if (resp_valid_reg && fault_reg) begin
      last_valid_next = 1'b1;
      if (fault_count_next != {FAULT_COUNT_W{1'b1}}) begin
        fault_count_next = fault_count_next + 16'h0001;
      end
    end
    if (reg_read_i) begin
      unique case (reg_addr_i)
        ROOT_PTR_OFFSET: begin
          rdata_next[ROOT_FORMAT_BIT] = root_format_reg;
        end
        LAST_FAULT_OFFSET: begin
          rdata_next[LAST_REASON_LSB +: 8] = reason_reg;
          rdata_next[LAST_QUAL_BIT]        = qual_reg;
          rdata_next[LAST_STATUS_LSB +: 2] = cpl_reg;
          rdata_next[LAST_VALID_BIT]       = last_valid_reg;
        end
        FAULT_COUNT_OFFSET: begin
          rdata_next[FAULT_COUNT_W-1:0] = fault_count_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      root_format_reg <= ROOT_FORMAT_RESET;
      fault_count_reg <= '0;
      last_valid_reg  <= 1'b0;
      rdata_reg       <= '0;
    end else begin
      root_format_reg <= root_format_next;
      fault_count_reg <= fault_count_next;
      last_valid_reg  <= last_valid_next;
      rdata_reg       <= rdata_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_o       = rdata_reg;
  assign resp_valid_o      = resp_valid_reg;
  assign resp_classified_o = classified_reg;
  assign fault_o           = fault_reg;
  assign fault_reason_o    = reason_reg;
  assign fault_qualified_o = qual_reg;
  assign cpl_status_o      = cpl_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_pasid_req;
    req_valid_i && request_address_kind_i == KIND_TRANSLATION && req_has_pasid_i;
  endsequence

  sequence s_root_ok;
    root_format_reg && !root_fetch_err_i && upper_lower_present_i;
  endsequence

  AST_NON_PASID_PASS: assert property (
    req_valid_i && !(request_address_kind_i == KIND_TRANSLATION && req_has_pasid_i)
    |=> resp_valid_o && !resp_classified_o && !fault_o && cpl_status_o == PTFC_CPL_SUCCESS)
    else $error("unclassified request reported a fault");

  AST_ROOT_FORMAT: assert property (
    s_pasid_req ##0 !root_format_reg
    |=> fault_o && fault_reason_o == 8'h1B && cpl_status_o == PTFC_CPL_UR)
    else $error("root format fault not reported");

  AST_ROOT_ABSENT: assert property (
    s_pasid_req ##0 root_format_reg && !root_fetch_err_i && !upper_lower_present_i
    |=> fault_reason_o == 8'h01 && !fault_qualified_o)
    else $error("root absent fault wrong");

  AST_ROOT_FETCH: assert property (
    s_pasid_req ##0 root_format_reg && root_fetch_err_i
    |=> fault_reason_o == 8'h08 && !fault_qualified_o && cpl_status_o == PTFC_CPL_CA)
    else $error("root fetch error fault wrong");

  AST_CTX_ABSENT: assert property (
    s_pasid_req ##0 s_root_ok ##0 !ctx_fetch_err_i && !ctx_present_i
    |=> fault_reason_o == 8'h02 && fault_qualified_o)
    else $error("context absent fault wrong");

  AST_UR_SET: assert property (
    resp_valid_o && fault_o && (fault_reason_o inside {8'h01, 8'h1B, 8'h02, 8'h0D,
      8'h10, 8'h11, 8'h19, 8'h1A}) |-> cpl_status_o == PTFC_CPL_UR)
    else $error("blocking fault without unsupported request");

  AST_CA_SET: assert property (
    resp_valid_o && fault_o && (fault_reason_o inside {8'h03, 8'h07, 8'h08, 8'h09})
    |-> cpl_status_o == PTFC_CPL_CA)
    else $error("error fault without completer abort");

  AST_ONE_ANSWER: assert property (
    resp_valid_o |-> $past(req_valid_i) && (fault_o == (fault_reason_o != 8'h00)))
    else $error("answer without request or reason mismatch");

  AST_HOLD: assert property (
    !req_valid_i |=> $stable(fault_reason_o) && $stable(fault_qualified_o) && !resp_valid_o)
    else $error("fault reason moved without a request");

  AST_CTX_FETCH: assert property (
    s_pasid_req ##0 s_root_ok ##0 ctx_fetch_err_i
    |=> fault_reason_o == 8'h09 && !fault_qualified_o && cpl_status_o == PTFC_CPL_CA)
    else $error("context fetch error fault wrong");

  AST_CTX_RSVD: assert property (
    s_pasid_req ##0 s_root_ok ##0 !ctx_fetch_err_i && ctx_present_i && ctx_reserved_nz_i
    |=> fault_reason_o == 8'h0B && fault_qualified_o && cpl_status_o == PTFC_CPL_UR)
    else $error("reserved field fault wrong");

endmodule

//--- ptfc_endpoint_model.sv
// Endpoint model: issues translation requests with their walk outcome.
// Assumes one rising-edge clock shared with the classifier.
`timescale 1ns/1ps
module ptfc_endpoint_model (
  input  wire logic        clk_i,
  output logic             req_valid_o,
  output logic [45:0]      req_bits_o
);
  logic [45:0] last_bits;

  // Quiet at time zero
  initial begin
    req_valid_o = 1'b0;
    req_bits_o  = '0;
    last_bits   = '0;
  end

  // One request per edge, back to back allowed
  task automatic send(input logic [45:0] b);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_bits_o  <= b;
    last_bits   = b;
  endtask

  // Walk lines are not held after the strobe, so flip them
  task automatic stop();
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_bits_o  <= ~last_bits;
  endtask
endmodule

//--- tb_ptfc_top.sv
// Self-checking bench for the translation fault classifier.
// Assumes 10 MHz clock, active-high async reset, endpoint model beside it.
`timescale 1ns/1ps
module tb_ptfc_top;
  import ptfc_pkg::*;
  typedef struct packed {
    logic [1:0] kind; logic has_pid; logic [19:0] pid; logic ex; logic sv;
    logic root_err; logic ulp; logic ctx_err; logic ctx_p; logic rsvd;
    logic [2:0] width; logic [2:0] tt; logic pide; logic [2:0] tsize; logic exa; logic sua;
    logic nest; logic ss_root_err; logic pid_err; logic ss_next_err;
  } ptfc_req_t;
  // Type 111b left unsupported so the programming fault on type is reachable
  localparam logic [7:0] TT_OK = 8'h22;
  localparam ptfc_req_t GOOD = '{kind: 2'h1, has_pid: 1'b1, ulp: 1'b1, ctx_p: 1'b1,
    width: 3'h2, tt: 3'h5, pide: 1'b1, default: '0};
  logic clk_i, reset_i, reg_write_i, reg_read_i, req_valid_i, vld_d, rd_d, fmt, seen;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [45:0] bits;
  logic [12:0] cur, last;
  logic [15:0] cnt;
  logic resp_valid_o, resp_classified_o, fault_o, fault_qualified_o;
  logic [7:0]  fault_reason_o;
  ptfc_cpl_t   cpl_status_o;
  ptfc_req_t   w, r;
  logic [12:0] q[$];
  logic [31:0] rq[$];
  int err_count, checks;
  assign w = ptfc_req_t'(bits);

  ptfc_endpoint_model ptfc_endpoint_model_i (
    .clk_i, .req_valid_o(req_valid_i), .req_bits_o(bits));
  ptfc_top #(.PASID_W(20), .WIDTH_SUPPORT_MASK(8'h04), .TT_SUPPORT_MASK(TT_OK)) ptfc_top_i (
    .clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
    .req_valid_i, .request_address_kind_i(w.kind), .req_has_pasid_i(w.has_pid),
    .req_pasid_i(w.pid), .exec_request_flag_i(w.ex), .supervisor_request_flag_i(w.sv),
    .root_fetch_err_i(w.root_err), .upper_lower_present_i(w.ulp),
    .ctx_fetch_err_i(w.ctx_err), .ctx_present_i(w.ctx_p), .ctx_reserved_nz_i(w.rsvd),
    .address_width_i(w.width), .ctx_translation_type_i(w.tt), .process_id_enable_i(w.pide),
    .process_id_table_size_i(w.tsize), .exec_request_allow_i(w.exa),
    .supervisor_request_allow_i(w.sua), .nested_enable_i(w.nest),
    .second_stage_root_err_i(w.ss_root_err), .process_id_entry_err_i(w.pid_err),
    .second_stage_next_err_i(w.ss_next_err), .resp_valid_o, .resp_classified_o,
    .fault_o, .fault_reason_o, .fault_qualified_o, .cpl_status_o);

  // ************************************************************
  // Expected answer, first fault in walk order wins
  // ************************************************************
  function automatic logic [12:0] classify(input ptfc_req_t x, input logic f);
    logic [7:0] c;
    logic ca;
    logic qu;
    ptfc_cpl_t st;
    c = FR_NONE;
    ca = 1'b0;
    if (x.kind !== KIND_TRANSLATION || !x.has_pid) return '0;
    if (!f) c = FR_ROOT_FORMAT;
    else if (x.root_err) c = FR_ROOT_FETCH_ERR;
    else if (!x.ulp) c = FR_ROOT_ABSENT;
    else if (x.ctx_err) c = FR_CTX_FETCH_ERR;
    else if (!x.ctx_p) c = FR_CTX_ABSENT;
    else if (x.rsvd) c = FR_CTX_RSVD;
    else if (x.width != 3'h2) c = FR_CTX_BAD_PROG;
    else if (!(x.tt inside {3'h1, 3'h5, 3'h7})) c = FR_TT_BLOCKED;
    else if (!TT_OK[x.tt]) c = FR_CTX_BAD_PROG;
    else if (!x.pide) c = FR_PID_DISABLED;
    else if (32'(x.pid) >= (32'h1 << (int'(x.tsize) + 5))) c = FR_PID_TOO_LARGE;
    else if (x.ex && !x.exa) c = FR_EXEC_DENIED;
    else if (x.sv && !x.sua) c = FR_SUPV_DENIED;
    else if (x.pid_err || (x.nest && x.ss_root_err)) c = FR_CTX_BAD_PROG;
    else if (x.ss_next_err) c = FR_SS_NEXT_ERR;
    ca = c inside {FR_CTX_BAD_PROG, FR_SS_NEXT_ERR, FR_ROOT_FETCH_ERR, FR_CTX_FETCH_ERR};
    qu = (c != FR_NONE) && !(c inside {8'h01, 8'h1B, 8'h08, 8'h09});
    st = (c == FR_NONE) ? PTFC_CPL_SUCCESS : (ca ? PTFC_CPL_CA : PTFC_CPL_UR);
    return {1'b1, c != FR_NONE, qu, st, c};
  endfunction

  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks++;
    if (seen_v !== exp_v) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  // Note the answer, the last-answer register and the fault count
  task automatic req(input ptfc_req_t x);
    logic [12:0] e;
    e = classify(x, fmt);
    q.push_back(e);
    last = e;
    if (e[11]) begin
      seen = 1'b1;
      if (cnt != 16'hFFFF) cnt++;
    end
    ptfc_endpoint_model_i.send(x);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    rq.push_back(e);
    @(posedge clk_i);
    reg_read_i <= 1'b0;
  endtask

  task automatic status_regs();
    ptfc_endpoint_model_i.stop();
    reg_rd(LAST_FAULT_OFFSET, {20'h0, seen, last[9:8], last[10], last[7:0]});
    reg_rd(FAULT_COUNT_OFFSET, {16'h0, cnt});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Watcher: latency, held answer fields and read data, every cycle
  always @(posedge clk_i) begin
    chk({31'h0, resp_valid_o}, {31'h0, vld_d});
    vld_d <= req_valid_i;
    if (resp_valid_o && q.size() > 0) cur = q.pop_front();
    chk({19'h0, resp_classified_o, fault_o, fault_qualified_o, cpl_status_o, fault_reason_o},
        {19'h0, cur});
    if (rd_d) chk(reg_rdata_o, rq.pop_front());
    else chk(reg_rdata_o, 32'h0);
    rd_d <= reg_read_i;
  end

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Bound: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end

  initial begin
    {reset_i, reg_write_i, reg_read_i, vld_d, rd_d, fmt, seen} = 7'h40;
    {reg_addr_i, reg_wdata_i, cur, last, cnt, err_count, checks} = '0;
    void'($urandom(32'h678BD774));
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    reg_rd(ROOT_PTR_OFFSET, 32'h0);
    reg_rd(8'h0C, 32'h0);
    $display("test reset_values done");
    req(GOOD);
    r = GOOD;
    r.kind = 2'h2;
    req(r);
    status_regs();
    reg_wr(8'h10, 32'h1);
    reg_wr(ROOT_PTR_OFFSET, 32'h1);
    fmt = 1'b1;
    reg_rd(ROOT_PTR_OFFSET, 32'h1);
    $display("test root_format done");
    for (int k = 0; k < 20; k++) begin
      r = GOOD;
      case (k)
        0: r.has_pid = 1'b0;
        1: r.root_err = 1'b1;
        2: r.ulp = 1'b0;
        3: r.ctx_err = 1'b1;
        4: r.ctx_p = 1'b0;
        5: r.rsvd = 1'b1;
        6: r.width = 3'h1;
        7: r.tt = 3'h3;
        8: r.tt = 3'h7;
        9: r.pide = 1'b0;
        10: r.pid = 20'h20;
        11: r.pid = 20'h1F;
        12: r.ex = 1'b1;
        13: r.sv = 1'b1;
        14: r.pid_err = 1'b1;
        15: {r.nest, r.ss_root_err} = 2'h3;
        16: r.ss_root_err = 1'b1;
        17: r.ss_next_err = 1'b1;
        18: {r.ulp, r.ctx_err, r.root_err} = 3'h3;
        default: {r.ex, r.exa, r.sv} = 3'h7;
      endcase
      req(r);
    end
    status_regs();
    $display("test each_condition done");
    reg_wr(FAULT_COUNT_OFFSET, 32'h0);
    {seen, cnt} = '0;
    reg_rd(FAULT_COUNT_OFFSET, 32'h0);
    $display("test count_clear done");
    for (int n = 0; n < 300; n++) begin
      r = GOOD;
      {r.pid, r.tsize, r.width, r.tt, r.ex, r.sv, r.exa, r.sua, r.nest} =
        34'({$urandom, $urandom});
      r.pid = r.pid >> 5'($urandom % 20);
      // Mostly a supported width, so later checks in the walk are reached
      if ($urandom % 4 != 0) r.width = 3'h2;
      {r.root_err, r.ctx_err, r.rsvd, r.ss_root_err, r.pid_err, r.ss_next_err} =
        6'($urandom & $urandom & $urandom);
      {r.ulp, r.ctx_p, r.pide, r.has_pid} = ~4'($urandom & $urandom & $urandom);
      if ($urandom % 16 == 0) r.kind = 2'($urandom);
      req(r);
    end
    status_regs();
    $display("test random_walks done");
    repeat (3) @(posedge clk_i);
    chk(32'(q.size() + rq.size()), 32'h0);
    wrap_up();
  end
endmodule
